// File: core/ferd_detector.sv
`timescale 1ns/1ps
module ferd_detector
   import ferd_pkg::*;
#(
   parameter logic [TAU_W-1:0] MIN_DELAY_LIMIT = MIN_DELAY_DEFAULT,
   parameter logic [TAU_W-1:0] MAX_DELAY_LIMIT = MAX_DELAY_DEFAULT
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Frame from the multiplex sublayer
   input wire logic frameValid,
   input wire ferd_frame_t frame,
   // Decision for the frame
   output logic resultValid,
   output ferd_result_t result
);

   ////////////////////////////////////////////////////////////////////////////
   ferd_state_t state;
   ferd_state_t next_state;

   // Whole frame decision in one cycle; the steps are chained so later checks
   // see the earlier outcome, and the delay checks may only raise the flag
   always_comb begin
      logic erased;
      ferd_rate_t rate;
      logic [TAU_W-1:0] tau;
      logic [TAU_W-1:0] prevTau;
      erased = 1'b0;
      rate = RATE_FULL;
      tau = state.tau;
      prevTau = '0;
      next_state = state;
      next_state.valid = 1'b0;
      if (frameValid) begin
         // Packet type decode
         case (frame.pktType)
            PKT_FULL, PKT_HALF, PKT_EIGHTH: erased = 1'b0;
            PKT_EIGHTH_ONES: erased = 1'b1;
            default: erased = 1'b1;
         endcase
         // Rate carried by the packet; an erased frame overrides it below, so
         // the promotion test only sees eighth rate with a full last valid rate for a real eighth packet
         case (frame.pktType)
            PKT_FULL: rate = RATE_FULL;
            PKT_HALF: rate = RATE_HALF;
            default: rate = RATE_EIGHTH;
         endcase
         if (erased) begin
            rate = (state.lastValidRate == RATE_EIGHTH) ? RATE_EIGHTH : RATE_FULL;
         end
         if (rate == RATE_EIGHTH && state.lastValidRate == RATE_FULL
               && !state.prevErased) begin
            erased = 1'b1;
            rate = RATE_FULL;
         end
         if (!erased) begin
            case (frame.pktType)
               PKT_FULL: rate = RATE_FULL;
               PKT_HALF: rate = RATE_HALF;
               default: rate = RATE_EIGHTH;
            endcase
            next_state.lastValidRate = rate;
         end
         // Delay code check follows rate selection
         if ((rate == RATE_HALF || rate == RATE_FULL)
               && frame.delayCode > DELAY_CODE_MAX) begin
            erased = 1'b1;
         end
         // Current delay, held across frames erased by packet type, promotion or delay code
         tau = erased ? state.tau : TAU_W'({2'h0, frame.delayCode}) + DELAY_OFFSET;
         // Difference check last; wraps below zero so it fails the max test
         prevTau = tau - TAU_W'({4'h0, frame.delay_difference_code}) - DELAY_DIFFERENCE_CODE_OFFSET;
         if (rate == RATE_FULL && (tau < TAU_W'({4'h0, frame.delay_difference_code})
               + DELAY_DIFFERENCE_CODE_OFFSET || prevTau < MIN_DELAY_LIMIT
               || prevTau > MAX_DELAY_LIMIT)) begin
            erased = 1'b1;
         end
         next_state.tau = tau;
         next_state.prevErased = erased;
         next_state.valid = 1'b1;
         next_state.result.frame_erasure_flag = erased;
         next_state.result.rate = rate;
         next_state.result.tau = tau;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state.lastValidRate <= LAST_RATE_RESET;
         state.prevErased <= 1'b0;
         state.tau <= TAU_RESET;
         state.valid <= 1'b0;
         state.result.frame_erasure_flag <= 1'b0;
         state.result.rate <= LAST_RATE_RESET;
         state.result.tau <= TAU_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from the state flops
   assign resultValid = state.valid;
   assign result = state.result;

   ////////////////////////////////////////////////////////////////////////////
   // Packet type table: erasing types must reach the flag whatever the state
   chk_ones_erased: assert property (@(posedge clock) disable iff (!rst_n)
      frameValid && frame.pktType == PKT_EIGHTH_ONES |=> result.frame_erasure_flag)
      else $error("all-ones eighth rate frame not erased");

   chk_type_erased: assert property (@(posedge clock) disable iff (!rst_n)
      frameValid && frame.pktType inside {PKT_QUARTER, PKT_BLANK, PKT_FULL_ERR,
      PKT_ERASURE} |=> result.frame_erasure_flag)
      else $error("erasing packet type not erased");

   // Erased frames fall back to eighth only after an eighth rate history
   chk_erased_rate: assert property (@(posedge clock) disable iff (!rst_n)
      frameValid && frame.pktType == PKT_BLANK && state.lastValidRate == RATE_EIGHTH
      |=> result.rate == RATE_EIGHTH)
      else $error("erased rate not eighth after eighth");

   // Other frames erased by packet type run at full rate
   chk_erased_full: assert property (@(posedge clock) disable iff (!rst_n)
      frameValid && frame.pktType inside {PKT_QUARTER, PKT_BLANK, PKT_FULL_ERR,
      PKT_ERASURE, PKT_EIGHTH_ONES} && state.lastValidRate != RATE_EIGHTH
      |=> result.rate == RATE_FULL)
      else $error("erased rate not full after higher rate");

   // Lone eighth rate frame after a good full rate frame is treated as lost
   chk_eighth_promote: assert property (@(posedge clock) disable iff (!rst_n)
      frameValid && frame.pktType == PKT_EIGHTH && state.lastValidRate == RATE_FULL
      && !state.prevErased |=> result.frame_erasure_flag && result.rate == RATE_FULL)
      else $error("eighth after full not promoted");

   // Normal eighth rate frame outside the promotion case is good
   chk_eighth_clear: assert property (@(posedge clock) disable iff (!rst_n)
      frameValid && frame.pktType == PKT_EIGHTH
      && !(state.lastValidRate == RATE_FULL && !state.prevErased)
      |=> !result.frame_erasure_flag && result.rate == RATE_EIGHTH)
      else $error("normal eighth rate frame erased");

   // Good frames store their rate for the next erasure
   chk_last_rate: assert property (@(posedge clock) disable iff (!rst_n)
      resultValid && !result.frame_erasure_flag |-> state.lastValidRate == result.rate)
      else $error("last valid rate not stored");

   // Delay code sanity check on half and full rate
   chk_delay_limit: assert property (@(posedge clock) disable iff (!rst_n)
      resultValid && result.rate != RATE_EIGHTH && $past(frame.delayCode) > DELAY_CODE_MAX
      |-> result.frame_erasure_flag)
      else $error("delay code above limit accepted");

   // Delay is held when the packet type itself erased the frame; the
   // difference check fires after the delay has already been taken
   chk_tau_hold: assert property (@(posedge clock) disable iff (!rst_n)
      resultValid && $past(frame.pktType) inside {PKT_QUARTER, PKT_BLANK, PKT_FULL_ERR,
      PKT_ERASURE, PKT_EIGHTH_ONES} |-> result.tau == $past(state.tau))
      else $error("erased frame changed the delay");

   // Good frames take code plus offset as the new delay
   chk_tau_good: assert property (@(posedge clock) disable iff (!rst_n)
      resultValid && !result.frame_erasure_flag
      |-> result.tau == TAU_W'($past(frame.delayCode)) + DELAY_OFFSET)
      else $error("good frame delay wrong");

   // Good full rate frames have a recovered delay inside the limits
   chk_diff_range: assert property (@(posedge clock) disable iff (!rst_n)
      resultValid && !result.frame_erasure_flag && result.rate == RATE_FULL
      |-> result.tau >= TAU_W'($past(frame.delay_difference_code)) + DELAY_DIFFERENCE_CODE_OFFSET
      + MIN_DELAY_LIMIT
      && result.tau <= TAU_W'($past(frame.delay_difference_code)) + DELAY_DIFFERENCE_CODE_OFFSET
      + MAX_DELAY_LIMIT)
      else $error("full rate delay difference out of range");

   // Previous erasure follows the final flag of every frame
   chk_prev_flag: assert property (@(posedge clock) disable iff (!rst_n)
      resultValid |-> state.prevErased == result.frame_erasure_flag)
      else $error("previous erasure not registered");

   // Good half rate frame with a sane delay code
   chk_good_clear: assert property (@(posedge clock) disable iff (!rst_n)
      frameValid && frame.pktType == PKT_HALF && frame.delayCode <= DELAY_CODE_MAX
      |=> !result.frame_erasure_flag && result.rate == RATE_HALF)
      else $error("good half rate frame erased");

   // One result per frame, exactly one cycle later
   chk_result_pulse: assert property (@(posedge clock) disable iff (!rst_n)
      frameValid |=> resultValid)
      else $error("frame without a result");
   chk_no_spurious: assert property (@(posedge clock) disable iff (!rst_n)
      !frameValid |=> !resultValid)
      else $error("result without a frame");

   // Result holds between frames
   chk_result_hold: assert property (@(posedge clock) disable iff (!rst_n)
      !resultValid |-> $stable(result))
      else $error("result changed between frames");

   // Initial state after reset
   chk_reset_state: assert property (@(posedge clock)
      !rst_n |=> !resultValid && !result.frame_erasure_flag
      && state.lastValidRate == LAST_RATE_RESET && !state.prevErased)
      else $error("reset state wrong");

endmodule : ferd_detector

// File: core/ferd_pkg.sv
package ferd_pkg;
   // Received packet type codes from the multiplex sublayer
   typedef enum logic [2:0] {
      PKT_FULL,
      PKT_HALF,
      PKT_QUARTER,
      PKT_EIGHTH,
      PKT_BLANK,
      PKT_FULL_ERR,
      PKT_ERASURE,
      PKT_EIGHTH_ONES
   } ferd_pkt_t;

   // Decoder rate of operation
   typedef enum logic [1:0] {
      RATE_EIGHTH,
      RATE_QUARTER,
      RATE_HALF,
      RATE_FULL
   } ferd_rate_t;

   localparam int DELAY_W = 7;
   localparam int DELAY_DIFFERENCE_CODE_W = 5;
   localparam int TAU_W = 9;
   localparam logic [DELAY_W-1:0] DELAY_CODE_MAX = 7'h64;
   localparam logic [TAU_W-1:0] DELAY_OFFSET = 9'h014;
   localparam logic [TAU_W-1:0] DELAY_DIFFERENCE_CODE_OFFSET = 9'h010;
   localparam logic [TAU_W-1:0] TAU_RESET = 9'h028;
   localparam logic [TAU_W-1:0] MIN_DELAY_DEFAULT = 9'h014;
   localparam logic [TAU_W-1:0] MAX_DELAY_DEFAULT = 9'h078;
   localparam ferd_rate_t LAST_RATE_RESET = RATE_EIGHTH;

   // One received frame
   typedef struct packed {
      ferd_pkt_t pktType;
      logic [DELAY_W-1:0] delayCode;
      logic [DELAY_DIFFERENCE_CODE_W-1:0] delay_difference_code;
   } ferd_frame_t;

   // Per-frame decision
   typedef struct packed {
      logic frame_erasure_flag;
      ferd_rate_t rate;
      logic [TAU_W-1:0] tau;
   } ferd_result_t;

   // Whole state of the detector
   typedef struct packed {
      ferd_rate_t lastValidRate;
      logic prevErased;
      logic [TAU_W-1:0] tau;
      logic valid;
      ferd_result_t result;
   } ferd_state_t;
endpackage : ferd_pkg

// File: bench/ferd_mux_model.sv
`timescale 1ns/1ps
module ferd_mux_model
   import ferd_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Requests from the bench
   input wire logic sendStrobe,
   input wire ferd_frame_t sendFrame,
   // Frame towards the detector
   output logic frameValid,
   output ferd_frame_t frame
);
   ////////////////////////////////////////////////////////////////////////////////
   // Between frames the fields flip every cycle, so a stale frame never looks valid
   always_ff @(posedge clock) begin
      frameValid <= rst_n & sendStrobe;
      if (!rst_n) begin
         frame <= '0;
      end else begin
         frame <= sendStrobe ? sendFrame : ~frame;
      end
   end
endmodule : ferd_mux_model

// File: bench/frame_erasure_rate_detector_test.sv
`timescale 1ns/1ps
module frame_erasure_rate_detector_test
   import ferd_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic sendStrobe = 1'b0;
   ferd_frame_t sendFrame = '0;
   logic frameValid;
   ferd_frame_t frame;
   logic resultValid;
   ferd_result_t result;
   int err_count = 0;
   int n_tests = 0;
   // Clock at 250 MHz
   always #2 clock = ~clock;
   ferd_mux_model model (.clock(clock), .rst_n(rst_n), .sendStrobe(sendStrobe),
      .sendFrame(sendFrame), .frameValid(frameValid), .frame(frame));
   // Low maximum so the upper limit of the difference check can be reached
   ferd_detector #(.MIN_DELAY_LIMIT(9'h014), .MAX_DELAY_LIMIT(9'h03c)) dut (.clock(clock),
      .rst_n(rst_n), .frameValid(frameValid), .frame(frame), .resultValid(resultValid),
      .result(result));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done
   task automatic expect_result(logic ef, ferd_rate_t er, logic [TAU_W-1:0] et);
      n_tests++;
      if (result !== ferd_result_t'{ef, er, et}) begin
         err_count++;
         $display("ERROR %0t result %h", $time, result);
      end
   endtask : expect_result
   // One frame through the sublayer model; the answer must come within a bounded wait
   task automatic send(ferd_pkt_t p, logic [DELAY_W-1:0] c, logic [DELAY_DIFFERENCE_CODE_W-1:0] d,
         logic ef, ferd_rate_t er, logic [TAU_W-1:0] et);
      int i;
      @(posedge clock);
      sendStrobe <= 1'b1;
      sendFrame <= '{p, c, d};
      @(posedge clock);
      sendStrobe <= 1'b0;
      #1;
      for (i = 0; i < 8 && resultValid !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      if (resultValid !== 1'b1) begin
         err_count++;
         $display("ERROR %0t no result", $time);
         test_done();
      end else begin
         expect_result(ef, er, et);
      end
   endtask : send
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      expect_result(1'b0, RATE_EIGHTH, 9'h028);
      send(PKT_QUARTER, 7'h00, 5'h00, 1'b1, RATE_EIGHTH, 9'h028);
      $display("test reset done");
   endtask : test_reset
   task automatic test_types();
      send(PKT_EIGHTH, 7'h0a, 5'h00, 1'b0, RATE_EIGHTH, 9'h01e);
      send(PKT_QUARTER, 7'h0a, 5'h00, 1'b1, RATE_EIGHTH, 9'h01e);
      send(PKT_BLANK, 7'h0a, 5'h00, 1'b1, RATE_EIGHTH, 9'h01e);
      send(PKT_EIGHTH_ONES, 7'h0a, 5'h00, 1'b1, RATE_EIGHTH, 9'h01e);
      send(PKT_ERASURE, 7'h0a, 5'h00, 1'b1, RATE_EIGHTH, 9'h01e);
      send(PKT_HALF, 7'h32, 5'h00, 1'b0, RATE_HALF, 9'h046);
      send(PKT_FULL_ERR, 7'h00, 5'h00, 1'b1, RATE_FULL, 9'h046);
      send(PKT_FULL, 7'h1e, 5'h0a, 1'b0, RATE_FULL, 9'h032);
      $display("test types done");
   endtask : test_types
   task automatic test_demote();
      send(PKT_EIGHTH, 7'h00, 5'h00, 1'b1, RATE_FULL, 9'h032);
      send(PKT_EIGHTH, 7'h05, 5'h00, 1'b0, RATE_EIGHTH, 9'h019);
      $display("test demote done");
   endtask : test_demote
   task automatic test_delay();
      send(PKT_HALF, 7'h64, 5'h00, 1'b0, RATE_HALF, 9'h078);
      send(PKT_HALF, 7'h65, 5'h00, 1'b1, RATE_HALF, 9'h078);
      send(PKT_EIGHTH, 7'h65, 5'h00, 1'b0, RATE_EIGHTH, 9'h079);
      $display("test delay done");
   endtask : test_delay
   task automatic test_diff();
      send(PKT_HALF, 7'h14, 5'h05, 1'b0, RATE_HALF, 9'h028);
      send(PKT_FULL, 7'h14, 5'h04, 1'b0, RATE_FULL, 9'h028);
      send(PKT_FULL, 7'h14, 5'h05, 1'b1, RATE_FULL, 9'h028);
      send(PKT_FULL, 7'h38, 5'h00, 1'b0, RATE_FULL, 9'h04c);
      send(PKT_FULL, 7'h39, 5'h00, 1'b1, RATE_FULL, 9'h04d);
      $display("test diff done");
   endtask : test_diff
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence, with a second reset after the last full rate frames
   initial begin
      test_reset();
      test_types();
      test_demote();
      test_delay();
      test_diff();
      test_reset();
      test_done();
   end
endmodule : frame_erasure_rate_detector_test
